// ### logic/eps_pkg.sv
// package: register map, field layout and carrier types for the pin request block
package eps_pkg;
  localparam int NUM_PINS = 12;
  localparam int ADDR_W = 4;
  // byte offsets of the word registers
  localparam logic [3:0] OFS_SENSE_LOWER = 4'h0;
  localparam logic [3:0] OFS_SENSE_UPPER = 4'h4;
  localparam logic [3:0] OFS_FLAGS = 4'h8;
  localparam logic [3:0] OFS_ENABLE = 4'hC;
  // reset values
  localparam logic [15:0] RST_SENSE_LOWER = 16'h0000;
  localparam logic [7:0] RST_SENSE_UPPER = 8'h00;
  localparam logic [11:0] RST_FLAGS = 12'h000;
  localparam logic [11:0] RST_ENABLE = 12'h000;
  // field layout
  localparam int SENSE_W = 2;
  localparam int SENSE_RISE_BIT = 1;
  localparam int SENSE_FALL_BIT = 0;
  localparam int LOWER_PINS = 8;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  // read data for unmapped addresses
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef logic [NUM_PINS-1:0] eps_pins_t;

  // avalon request as one bundle
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } eps_req_s;

  // acknowledge events from the core and transfer controller
  typedef struct packed {
    eps_pins_t exc_ack;
    eps_pins_t xfer_ack;
    logic xfer_int_select;
  } eps_ack_s;
endpackage

// ### logic/eps_pin_sync.sv
// two-flop synchroniser and edge detect for the active-low request pins
`timescale 1ns/1ps
module eps_pin_sync (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire eps_pkg::eps_pins_t pin_n_in, // raw active-low pins
  output eps_pkg::eps_pins_t level_low_out, // synchronised pin is low
  output eps_pkg::eps_pins_t fall_out, // one-cycle falling-edge pulse
  output eps_pkg::eps_pins_t rise_out // one-cycle rising-edge pulse
);
  eps_pkg::eps_pins_t stage1;
  eps_pkg::eps_pins_t stage2;
  eps_pkg::eps_pins_t prev;

  // reset to idle-high so no edge is seen on release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= '1;
      stage2 <= '1;
      prev <= '1;
    end else begin
      stage1 <= pin_n_in;
      stage2 <= stage1;
      prev <= stage2;
    end
  end

  // only stage2 and prev feed logic; stage1 stays private
  assign level_low_out = ~stage2;
  assign fall_out = prev & ~stage2;
  assign rise_out = ~prev & stage2;
endmodule

// ### logic/eps_sense_sel.sv
// per-pin selection of the detection condition from its sense field
`timescale 1ns/1ps
module eps_sense_sel (
  input wire logic [1:0] sense_in, // rise bit upper, fall bit lower
  input wire logic low_in, // synchronised pin low
  input wire logic fall_in, // falling-edge pulse
  input wire logic rise_in, // rising-edge pulse
  output logic set_out // condition met this cycle
);
  always_comb begin
    case (sense_in)
      eps_pkg::SENSE_LOW: set_out = low_in;
      eps_pkg::SENSE_FALL: set_out = fall_in;
      eps_pkg::SENSE_RISE: set_out = rise_in;
      default: set_out = fall_in | rise_in;
    endcase
  end
endmodule

// ### logic/eps_irq_sense.sv
// top: external pin request sensing, flags, enables and avalon register slave
`timescale 1ns/1ps
// Function
// - sense field selects low, fall, rise, both
// - lower sense register holds pins 7..0
// - one request flag per pin, reset zero
// - flag sets on selected pin condition
// - write zero clears only after read one
// - exception clears low-level flag if pin high
// - exception clears edge-mode flag
// - transfer activation clears flag when select zero
// - flag bits 15..12 read as zero
// - upper sense register holds pins 11..8
// - flag forwarded only while enabled
module eps_irq_sense (
  input wire logic CLK_IN, // 10 MHz system clock
  input wire logic RST_N_IN, // async reset, active low
  input wire logic [3:0] AVS_ADDRESS_IN, // byte address
  input wire logic AVS_READ_IN, // read strobe
  input wire logic AVS_WRITE_IN, // write strobe
  input wire logic [3:0] AVS_BYTEENABLE_IN, // byte lanes
  input wire logic [31:0] AVS_WRITEDATA_IN, // write data
  output logic [31:0] AVS_READDATA_OUT, // read data, registered
  output logic AVS_WAITREQUEST_OUT, // stall while access not done
  input wire logic [11:0] IRQ_PIN_N_IN, // external request pins, active low
  input wire logic [11:0] EXC_ACK_IN, // exception handling taken, per pin pulse
  input wire logic [11:0] XFER_ACK_IN, // transfer controller activated, per pin pulse
  input wire logic XFER_INT_SELECT_IN, // transfer controller interrupt-select bit
  output logic [11:0] PIN_REQ_OUT, // enabled requests toward the processor
  output logic IRQ_OUT // any unmasked flag set, level
);
  eps_pkg::eps_req_s req;
  eps_pkg::eps_ack_s ack;
  logic [15:0] sense_control_lower;
  logic [7:0] sense_control_upper;
  eps_pkg::eps_pins_t pin_request_flags;
  eps_pkg::eps_pins_t pin_request_enable_reg;
  eps_pkg::eps_pins_t read_one_seen;
  eps_pkg::eps_pins_t level_low;
  eps_pkg::eps_pins_t fall_pulse;
  eps_pkg::eps_pins_t rise_pulse;
  eps_pkg::eps_pins_t set_evt;
  eps_pkg::eps_pins_t sw_clr;
  eps_pkg::eps_pins_t hw_clr;
  eps_pkg::eps_pins_t next_flags;
  logic [23:0] sense_all;
  logic done;
  logic access;
  logic wr_en;
  logic rd_en;
  logic sel_lower;
  logic sel_upper;
  logic sel_flags;
  logic sel_enable;
  eps_pkg::eps_pins_t exc_clr;
  eps_pkg::eps_pins_t xfer_clr;
  eps_pkg::eps_pins_t next_seen;
  logic [31:0] next_readdata;

  // register map, one 32-bit word each, only the low half used:
  //   sense lower: two bits per pin, pins 7..0, rise bit above fall bit
  //   sense upper: same layout for pins 11..8 in its low byte
  //   request flags: one sticky bit per pin, cleared by writing zero
  //   request enables: one bit per pin, gate toward the processor
  // unused upper bits read as zero and ignore writes

  // pin behaviour:
  //   pins are active low and idle high; the synchroniser resets high
  //   so that leaving reset never looks like an edge
  //   low-level mode keeps setting the flag while the pin is held low
  //   edge modes set it once per selected transition

  // bundle the bus and acknowledge inputs
  assign req = '{address: AVS_ADDRESS_IN, read: AVS_READ_IN, write: AVS_WRITE_IN,
                 byteenable: AVS_BYTEENABLE_IN, writedata: AVS_WRITEDATA_IN};
  assign ack = '{exc_ack: EXC_ACK_IN, xfer_ack: XFER_ACK_IN, xfer_int_select: XFER_INT_SELECT_IN};

  // byte lane test, shared by every write path
  function automatic logic lane_hit(input logic [3:0] be, input int lane);
    return be[lane];
  endfunction

  // sense field of one pin out of the packed lower and upper fields
  function automatic logic [1:0] sense_of(input logic [23:0] all, input int pin);
    return all[pin*eps_pkg::SENSE_W +: eps_pkg::SENSE_W];
  endfunction

  // bus timing: every access waits exactly one cycle
  //   first cycle: waitrequest high, read data is fetched into the output flop
  //   second cycle: waitrequest low, read data stands, a write lands at its end
  // a write lands only at the edge where the master sees waitrequest low,
  // so nothing changes while the master could still be stalled
  assign access = req.read | req.write;
  assign AVS_WAITREQUEST_OUT = access & ~done;
  assign wr_en = req.write & done;
  assign rd_en = req.read & ~done;

  // address decode shared by the write, clear and read paths
  assign sel_lower = (req.address == eps_pkg::OFS_SENSE_LOWER);
  assign sel_upper = (req.address == eps_pkg::OFS_SENSE_UPPER);
  assign sel_flags = (req.address == eps_pkg::OFS_FLAGS);
  assign sel_enable = (req.address == eps_pkg::OFS_ENABLE);

  // done marks the completion cycle; drops so back-to-back requests each wait
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      done <= 1'b0;
    end else begin
      done <= access & ~done;
    end
  end

  // pin synchroniser and edge detector
  // a pin change reaches the flags three edges after it is applied;
  // pulses narrower than a clock period may be missed, the price of
  // keeping asynchronous pins away from the flag logic
  eps_pin_sync u_sync (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .pin_n_in(IRQ_PIN_N_IN),
    .level_low_out(level_low),
    .fall_out(fall_pulse),
    .rise_out(rise_pulse)
  );

  // pins 7..0 from the lower register, 11..8 from the upper
  assign sense_all = {sense_control_upper, sense_control_lower};

  // one selector per pin
  genvar gi;
  generate
    for (gi = 0; gi < eps_pkg::NUM_PINS; gi++) begin : g_pin
      eps_sense_sel u_sel (
        .sense_in(sense_of(sense_all, gi)),
        .low_in(level_low[gi]),
        .fall_in(fall_pulse[gi]),
        .rise_in(rise_pulse[gi]),
        .set_out(set_evt[gi])
      );
      // exception clear: low mode only once the pin is back high, else the
      // request would be dropped while the device still holds it
      always_comb begin
        exc_clr[gi] = 1'b0;
        if (ack.exc_ack[gi]) begin
          if (sense_of(sense_all, gi) == eps_pkg::SENSE_LOW) begin
            exc_clr[gi] = ~level_low[gi];
          end else begin
            exc_clr[gi] = 1'b1;
          end
        end
      end
    end
  endgenerate

  // transfer activation clears only when the controller passes no interrupt on
  assign xfer_clr = ack.xfer_ack & {eps_pkg::NUM_PINS{~ack.xfer_int_select}};
  // all hardware clears of one pin
  assign hw_clr = exc_clr | xfer_clr;

  // write zero clears only bits that were read as one before
  // a one written to a flag, or a zero to an unread flag, does nothing
  always_comb begin
    sw_clr = '0;
    if (wr_en && sel_flags) begin
      for (int i = 0; i < eps_pkg::NUM_PINS; i++) begin
        if (lane_hit(req.byteenable, i / 8) && !req.writedata[i]) begin
          sw_clr[i] = read_one_seen[i];
        end
      end
    end
  end

  // flag update, one term per source:
  //   set: the condition chosen by the pin's sense field
  //   clear: software zero after a read of one, exception, transfer
  // set beats clear so an event in the clearing cycle survives
  assign next_flags = (pin_request_flags & ~(sw_clr | hw_clr)) | set_evt;

  // request flags
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_request_flags <= eps_pkg::RST_FLAGS;
    end else begin
      pin_request_flags <= next_flags;
    end
  end

  // remember which flags software has seen as one; a clear consumes it
  // a fresh read replaces the record, so a stale zero never clears a flag
  // that was set after the read; software must read again first
  always_comb begin
    next_seen = read_one_seen & ~sw_clr;
    if (rd_en && sel_flags) begin
      next_seen = pin_request_flags;
    end
  end

  // read-one record
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      read_one_seen <= '0;
    end else begin
      read_one_seen <= next_seen;
    end
  end

  // sense control registers, byte-lane writes
  // a sense change can make the detector see a false edge or level;
  // the flag is not masked here, software disables and clears around it
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sense_control_lower <= eps_pkg::RST_SENSE_LOWER;
      sense_control_upper <= eps_pkg::RST_SENSE_UPPER;
    end else if (wr_en) begin
      if (sel_lower) begin
        if (lane_hit(req.byteenable, 0)) begin
          sense_control_lower[7:0] <= req.writedata[7:0];
        end
        if (lane_hit(req.byteenable, 1)) begin
          sense_control_lower[15:8] <= req.writedata[15:8];
        end
      end
      if (sel_upper && lane_hit(req.byteenable, 0)) begin
        sense_control_upper <= req.writedata[7:0];
      end
    end
  end

  // per-pin enables; software should hold a pin disabled while changing its sense
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_request_enable_reg <= eps_pkg::RST_ENABLE;
    end else if (wr_en && sel_enable) begin
      if (lane_hit(req.byteenable, 0)) begin
        pin_request_enable_reg[7:0] <= req.writedata[7:0];
      end
      if (lane_hit(req.byteenable, 1)) begin
        pin_request_enable_reg[11:8] <= req.writedata[11:8];
      end
    end
  end

  // read word mux; reserved and unmapped bits come back as zero
  always_comb begin
    case (req.address)
      eps_pkg::OFS_SENSE_LOWER: next_readdata = {16'h0000, sense_control_lower};
      eps_pkg::OFS_SENSE_UPPER: next_readdata = {24'h000000, sense_control_upper};
      eps_pkg::OFS_FLAGS: next_readdata = {20'h00000, pin_request_flags};
      eps_pkg::OFS_ENABLE: next_readdata = {20'h00000, pin_request_enable_reg};
      default: next_readdata = eps_pkg::UNMAPPED_READ;
    endcase
  end

  // read data loaded in the waiting cycle and held until the next read,
  // so it stands through the cycle in which the master takes it
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      AVS_READDATA_OUT <= eps_pkg::UNMAPPED_READ;
    end else if (rd_en) begin
      AVS_READDATA_OUT <= next_readdata;
    end
  end

  // forwarding gated by enables; combined level interrupt
  // the flag itself is never masked, so a disabled pin still records
  // its event and raises the interrupt as soon as it is enabled
  assign PIN_REQ_OUT = pin_request_flags & pin_request_enable_reg;
  assign IRQ_OUT = |(pin_request_flags & pin_request_enable_reg);
endmodule

// ### test/eps_pin_dev.sv
// partner: external devices driving the active-low request pins
`timescale 1ns/1ps
module eps_pin_dev (
  input wire logic clk_in, // system clock
  input wire logic [11:0] assert_in, // 1 = device asserts its request
  output logic [11:0] pin_n_out // active-low pins, idle high by pull-up
);
  // pins start released, so the pull-up holds them high
  initial pin_n_out = 12'hFFF;
  // devices move their lines just after an edge, never on the sampling edge
  always @(posedge clk_in) begin
    pin_n_out <= ~assert_in;
  end
endmodule

// ### test/eps_irq_sense_assertions.sv
// checker: port-level assertions for the pin request block
`timescale 1ns/1ps
module eps_irq_sense_chk (
  input wire logic CLK_IN, // clock
  input wire logic RST_N_IN, // reset
  input wire logic [3:0] AVS_ADDRESS_IN, // address
  input wire logic AVS_READ_IN, // read
  input wire logic AVS_WRITE_IN, // write
  input wire logic [3:0] AVS_BYTEENABLE_IN, // lanes
  input wire logic [31:0] AVS_WRITEDATA_IN, // write data
  input wire logic [31:0] AVS_READDATA_OUT, // read data
  input wire logic AVS_WAITREQUEST_OUT, // stall
  input wire logic [11:0] IRQ_PIN_N_IN, // pins
  input wire logic [11:0] EXC_ACK_IN, // exception acks
  input wire logic [11:0] XFER_ACK_IN, // transfer acks
  input wire logic XFER_INT_SELECT_IN, // transfer select
  input wire logic [11:0] PIN_REQ_OUT, // requests
  input wire logic IRQ_OUT // interrupt
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic rd_ok;
  logic wr_ok;
  // completed accesses
  assign rd_ok = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
  assign wr_ok = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  wait_once_a: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("access stalled too long");
  lower_width_a: assert property (rd_ok && AVS_ADDRESS_IN == eps_pkg::OFS_SENSE_LOWER |->
    AVS_READDATA_OUT[31:16] == 16'h0000) else $error("lower sense high bits set");
  upper_width_a: assert property (rd_ok && AVS_ADDRESS_IN == eps_pkg::OFS_SENSE_UPPER |->
    AVS_READDATA_OUT[31:8] == 24'h000000) else $error("upper sense reserved bits set");
  flag_width_a: assert property (rd_ok && AVS_ADDRESS_IN == eps_pkg::OFS_FLAGS |->
    AVS_READDATA_OUT[31:12] == 20'h00000) else $error("flag reserved bits set");
  ones_write_a: assert property (wr_ok && AVS_ADDRESS_IN == eps_pkg::OFS_FLAGS && AVS_BYTEENABLE_IN == 4'hF &&
    AVS_WRITEDATA_IN[11:0] == 12'hFFF |=> ($past(PIN_REQ_OUT) & ~PIN_REQ_OUT) == 12'h000)
    else $error("write of ones cleared a flag");
  flag_sticky_a: assert property (!AVS_WRITE_IN && EXC_ACK_IN == 12'h000 && XFER_ACK_IN == 12'h000 |=>
    ($past(PIN_REQ_OUT) & ~PIN_REQ_OUT) == 12'h000) else $error("flag dropped without cause");
  xsel_hold_a: assert property (!AVS_WRITE_IN && EXC_ACK_IN == 12'h000 && XFER_INT_SELECT_IN |=>
    ($past(PIN_REQ_OUT) & ~PIN_REQ_OUT) == 12'h000) else $error("transfer cleared flag with select set");
  irq_or_a: assert property (IRQ_OUT == (|PIN_REQ_OUT)) else $error("irq not or of requests");
  reset_clear_a: assert property ($rose(RST_N_IN) |-> PIN_REQ_OUT == 12'h000) else $error("requests after reset");
  cover property (rd_ok && AVS_ADDRESS_IN == eps_pkg::OFS_FLAGS);
  cover property ($rose(IRQ_OUT));
  cover property (EXC_ACK_IN != 12'h000 && PIN_REQ_OUT != 12'h000);
endmodule
bind eps_irq_sense eps_irq_sense_chk i_chk (.CLK_IN, .RST_N_IN, .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN,
  .AVS_BYTEENABLE_IN, .AVS_WRITEDATA_IN, .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .IRQ_PIN_N_IN, .EXC_ACK_IN,
  .XFER_ACK_IN, .XFER_INT_SELECT_IN, .PIN_REQ_OUT, .IRQ_OUT);

// ### test/eps_irq_sense_tb.sv
// testbench: register, sense-mode, clear and mask scenarios for the pin request block
`timescale 1ns/1ps
module eps_irq_sense_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wreq;
  logic [11:0] lvl = 12'h000;
  logic [11:0] pin_n;
  logic [11:0] exc = 12'h000;
  logic [11:0] xfr = 12'h000;
  logic xsel = 1'b0;
  logic [11:0] preq;
  logic irq;
  logic [31:0] v;
  int mismatches = 0;
  int checks_done = 0;
  initial forever #50 clk = ~clk;
  eps_pin_dev i_dev (.clk_in(clk), .assert_in(lvl), .pin_n_out(pin_n));
  eps_irq_sense i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_BYTEENABLE_IN(be), .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
    .IRQ_PIN_N_IN(pin_n), .EXC_ACK_IN(exc), .XFER_ACK_IN(xfr), .XFER_INT_SELECT_IN(xsel), .PIN_REQ_OUT(preq),
    .IRQ_OUT(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one access: hold until waitrequest is seen low, then release and idle a cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    v = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(v, exp);
  endtask
  // read first so the write of zero clears only what was seen set
  task automatic clr();
    bus(1'b0, eps_pkg::OFS_FLAGS, 32'h0);
    bus(1'b1, eps_pkg::OFS_FLAGS, 32'h0);
  endtask
  task automatic ack(input logic [11:0] e, input logic [11:0] x);
    exc <= e;
    xfr <= x;
    @(posedge clk);
    exc <= 12'h000;
    xfr <= 12'h000;
    repeat (2) @(posedge clk);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(eps_pkg::OFS_SENSE_LOWER, 32'h0);
    rdc(eps_pkg::OFS_SENSE_UPPER, 32'h0);
    rdc(eps_pkg::OFS_FLAGS, 32'h0);
    rdc(eps_pkg::OFS_ENABLE, 32'h0);
    bus(1'b1, eps_pkg::OFS_SENSE_UPPER, 32'hFFFF_FFFF);
    rdc(eps_pkg::OFS_SENSE_UPPER, 32'h0000_00FF);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    rdc(4'h2, 32'h0);
    // byte lanes: only the enabled lane of a word is written
    be <= 4'h2;
    bus(1'b1, eps_pkg::OFS_SENSE_LOWER, 32'h0000_A5A5);
    be <= 4'hF;
    rdc(eps_pkg::OFS_SENSE_LOWER, 32'h0000_A500);
    be <= 4'h1;
    bus(1'b1, eps_pkg::OFS_ENABLE, 32'h0000_0FFF);
    be <= 4'hF;
    rdc(eps_pkg::OFS_ENABLE, 32'h0000_00FF);
    bus(1'b1, eps_pkg::OFS_FLAGS, 32'h0000_FFFF);
    rdc(eps_pkg::OFS_FLAGS, 32'h0);
    bus(1'b1, eps_pkg::OFS_ENABLE, 32'h0000_0FFF);
    // every sense mode on pin 7 (lower) and pin 11 (upper)
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, eps_pkg::OFS_SENSE_LOWER, 32'(m) << 14);
      bus(1'b1, eps_pkg::OFS_SENSE_UPPER, 32'(m) << 6);
      clr();
      lvl <= 12'h880;
      repeat (5) @(posedge clk);
      chk(preq, (m == 2) ? 32'h0 : 32'h880);
      chk(irq, m != 2);
      lvl <= 12'h000;
      repeat (5) @(posedge clk);
      rdc(eps_pkg::OFS_FLAGS, 32'h880);
      clr();
      rdc(eps_pkg::OFS_FLAGS, 32'h0);
    end
    // pin 7 falling edge, pin 11 low level; stale zero read must not allow a clear
    bus(1'b1, eps_pkg::OFS_SENSE_LOWER, 32'h4000);
    bus(1'b1, eps_pkg::OFS_SENSE_UPPER, 32'h0);
    clr();
    rdc(eps_pkg::OFS_FLAGS, 32'h0);
    lvl <= 12'h080;
    repeat (5) @(posedge clk);
    bus(1'b1, eps_pkg::OFS_FLAGS, 32'h0);
    rdc(eps_pkg::OFS_FLAGS, 32'h080);
    bus(1'b1, eps_pkg::OFS_FLAGS, 32'h0FFF);
    rdc(eps_pkg::OFS_FLAGS, 32'h080);
    bus(1'b1, eps_pkg::OFS_ENABLE, 32'h0);
    chk({irq, preq}, 32'h0);
    bus(1'b1, eps_pkg::OFS_ENABLE, 32'h0FFF);
    ack(12'h080, 12'h000);
    rdc(eps_pkg::OFS_FLAGS, 32'h0);
    lvl <= 12'h880;
    repeat (5) @(posedge clk);
    ack(12'h800, 12'h000);
    rdc(eps_pkg::OFS_FLAGS, 32'h800);
    lvl <= 12'h080;
    repeat (5) @(posedge clk);
    ack(12'h800, 12'h000);
    rdc(eps_pkg::OFS_FLAGS, 32'h0);
    lvl <= 12'h000;
    repeat (5) @(posedge clk);
    lvl <= 12'h080;
    repeat (5) @(posedge clk);
    xsel <= 1'b1;
    ack(12'h000, 12'h080);
    rdc(eps_pkg::OFS_FLAGS, 32'h080);
    xsel <= 1'b0;
    ack(12'h000, 12'h080);
    rdc(eps_pkg::OFS_FLAGS, 32'h0);
    close_out();
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule
